/* uepc_top.sv */
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uepc_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 srst,
    // APB slave.
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Token from the packet engine.
    input  wire logic                 tok_valid,
    input  wire logic [3:0]           tok_ep,
    input  wire uepc_pkg::uepc_tok_t  tok_kind,
    output logic                      resp_valid,
    output uepc_pkg::uepc_resp_t      resp_code,
    // Frame and iso IN events, one-cycle pulses.
    input  wire logic                 iso_in_extra_token,
    input  wire logic                 iso_in_no_data,
    input  wire logic                 extra_frame_start,
    input  wire logic                 frame_start_lost,
    output logic                      second_status_summary,
    // Endpoint configuration towards the data path.
    output logic [6:0]                ep_enable,
    output logic [6:0]                control_max_packet,
    output logic [9:0]                iso_in_max_packet,
    output logic [9:0]                iso_out_max_packet,
    output logic [6:0]                bulk_in_max_packet,
    output logic [6:0]                bulk_out_max_packet,
    output logic [6:0]                intr_in_max_packet,
    output logic [6:0]                intr_out_max_packet,
    output logic                      iso_in_tx_mode,
    output logic                      bulk_in_tx_mode,
    output uepc_pkg::uepc_rx_mode_t   iso_out_rx_mode,
    output uepc_pkg::uepc_rx_mode_t   bulk_out_rx_mode,
    output logic                      iso_out_report_per_packet,
    output logic                      bulk_out_report_per_packet,
    output logic                      rate_feedback_select
);

    initial begin
        if (ADDR_W < 6) begin
            $error("ADDR_W too small for the register map");
        end
    end

    logic [31:0]           ep_ctrl [0:uepc_pkg::NUM_EP-1];
    logic [3:0]            second_status;
    logic [3:0]            second_status_mask;
    logic                  control_stall_latched, bus_access, bus_write, bus_read;
    logic                  hit_ep, hit_st, hit_mask, tok_setup_ep0;
    logic [2:0]            hit_idx;
    logic [31:0]           next_prdata;
    logic [3:0]            st_events;
    uepc_pkg::uepc_resp_t  next_resp;

    function automatic logic [31:0] wmask(input logic [2:0] idx);
        case (idx)
            3'h0: wmask = uepc_pkg::WMASK_EP0;
            3'h1: wmask = uepc_pkg::WMASK_EP1;
            3'h2: wmask = uepc_pkg::WMASK_EP2;
            3'h3: wmask = uepc_pkg::WMASK_EP3;
            3'h4: wmask = uepc_pkg::WMASK_EP4;
            3'h5: wmask = uepc_pkg::WMASK_EP5;
            default: wmask = uepc_pkg::WMASK_EP6;
        endcase
    endfunction

    function automatic uepc_pkg::uepc_rx_mode_t rx_mode(input logic [1:0] f);
        case (f)
            2'h2: rx_mode = uepc_pkg::UEPC_RX_ASSEMBLE;
            2'h3: rx_mode = uepc_pkg::UEPC_RX_SEPARATE;
            default: rx_mode = uepc_pkg::UEPC_RX_NORMAL;
        endcase
    endfunction

    function automatic uepc_pkg::uepc_resp_t out_resp(input logic stall, nak, no_hsk);
        if (stall) begin
            out_resp = uepc_pkg::UEPC_RESP_STALL;
        end else if (nak) begin
            out_resp = uepc_pkg::UEPC_RESP_NAK;
        end else if (no_hsk) begin
            out_resp = uepc_pkg::UEPC_RESP_NONE;
        end else begin
            out_resp = uepc_pkg::UEPC_RESP_ACK;
        end
    endfunction

    function automatic uepc_pkg::uepc_resp_t in_resp(input logic stall, nak);
        if (stall) begin
            in_resp = uepc_pkg::UEPC_RESP_STALL;
        end else if (nak) begin
            in_resp = uepc_pkg::UEPC_RESP_NAK;
        end else begin
            in_resp = uepc_pkg::UEPC_RESP_DATA;
        end
    endfunction

    // The slave answers in the first access cycle, so reads and writes act there.
    assign bus_access = psel && penable;
    assign bus_write  = bus_access && pwrite;
    assign bus_read   = bus_access && !pwrite;
    assign pready     = 1'b1;
    assign tok_setup_ep0 = tok_valid && (tok_ep == 4'h0) && (tok_kind == uepc_pkg::UEPC_TOK_SETUP);

    always_comb begin
        hit_ep   = 1'b0;
        hit_st   = 1'b0;
        hit_mask = 1'b0;
        hit_idx  = 3'h0;
        if (paddr == ADDR_W'(uepc_pkg::OFS_CONTROL_ENDPOINT_CTRL)) begin
            hit_ep  = 1'b1;
            hit_idx = 3'h0;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_ISO_IN_ENDPOINT_CTRL)) begin
            hit_ep  = 1'b1;
            hit_idx = 3'h1;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_ISO_OUT_ENDPOINT_CTRL)) begin
            hit_ep  = 1'b1;
            hit_idx = 3'h2;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_BULK_IN_ENDPOINT_CTRL)) begin
            hit_ep  = 1'b1;
            hit_idx = 3'h3;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_BULK_OUT_ENDPOINT_CTRL)) begin
            hit_ep  = 1'b1;
            hit_idx = 3'h4;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_INTR_IN_ENDPOINT_CTRL)) begin
            hit_ep  = 1'b1;
            hit_idx = 3'h5;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_INTR_OUT_ENDPOINT_CTRL)) begin
            hit_ep  = 1'b1;
            hit_idx = 3'h6;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_SECOND_STATUS)) begin
            hit_st = 1'b1;
        end else if (paddr == ADDR_W'(uepc_pkg::OFS_SECOND_STATUS_MASK)) begin
            hit_mask = 1'b1;
        end
    end

    always_comb begin
        next_prdata = 32'h00000000;
        if (hit_ep) begin
            next_prdata = ep_ctrl[hit_idx];
        end else if (hit_st) begin
            next_prdata = {28'h0000000, second_status};
        end else if (hit_mask) begin
            next_prdata = {28'h0000000, second_status_mask};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= next_prdata;
            pslverr <= !(hit_ep || hit_st || hit_mask);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < uepc_pkg::NUM_EP; i++) begin
                ep_ctrl[i] <= uepc_pkg::RESET_EP;
            end
        end else begin
            if (tok_setup_ep0) begin
                ep_ctrl[uepc_pkg::EP_CTRL][uepc_pkg::POS_IN_STALL] <= 1'b0;
                ep_ctrl[uepc_pkg::EP_CTRL][uepc_pkg::POS_STALL]    <= 1'b0;
            end
            if (bus_write && hit_ep) begin
                ep_ctrl[hit_idx] <= pwdata & wmask(hit_idx);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            control_stall_latched <= 1'b0;
        end else if (tok_setup_ep0) begin
            control_stall_latched <= 1'b0;
        end else if (tok_valid && tok_ep == 4'h0 && ep_ctrl[uepc_pkg::EP_CTRL][31]
                     && next_resp == uepc_pkg::UEPC_RESP_STALL) begin
            control_stall_latched <= 1'b1;
        end
    end

    always_comb begin
        logic [31:0] r;
        logic        is_in;
        r         = 32'h00000000;
        is_in     = (tok_kind == uepc_pkg::UEPC_TOK_IN);
        next_resp = uepc_pkg::UEPC_RESP_NONE;
        if (tok_ep < 4'h7) begin
            r = ep_ctrl[tok_ep[2:0]];
        end
        if (tok_ep >= 4'h7 || !r[uepc_pkg::POS_ENABLE]) begin
            next_resp = uepc_pkg::UEPC_RESP_NONE;
        end else if (tok_ep == 4'h0) begin
            if (tok_kind == uepc_pkg::UEPC_TOK_SETUP) begin
                next_resp = uepc_pkg::UEPC_RESP_ACK;
            end else if (control_stall_latched) begin
                next_resp = uepc_pkg::UEPC_RESP_STALL;
            end else if (is_in) begin
                // IN stall. IN NAK. stall first.
                next_resp = in_resp(r[uepc_pkg::POS_IN_STALL], r[uepc_pkg::POS_IN_NAK]);
            end else begin
                // OUT stall. OUT NAK. no handshake.
                next_resp = out_resp(r[uepc_pkg::POS_STALL], r[uepc_pkg::POS_NAK],
                                     r[uepc_pkg::POS_NO_HSK]);
            end
        end else if (tok_ep == 4'h1) begin
            if (is_in) begin
                next_resp = uepc_pkg::UEPC_RESP_DATA;
            end
        end else if (tok_ep == 4'h2) begin
            if (tok_kind == uepc_pkg::UEPC_TOK_OUT) begin
                next_resp = uepc_pkg::UEPC_RESP_NONE;
            end
        end else if (tok_ep == 4'h3 || tok_ep == 4'h5) begin
            // bulk IN forcing. interrupt IN forcing.
            if (is_in) begin
                next_resp = in_resp(r[uepc_pkg::POS_STALL], r[uepc_pkg::POS_NAK]);
            end
        end else begin
            if (tok_kind == uepc_pkg::UEPC_TOK_OUT) begin
                next_resp = out_resp(r[uepc_pkg::POS_STALL], r[uepc_pkg::POS_NAK],
                                     r[uepc_pkg::POS_NO_HSK]);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            resp_valid <= 1'b0;
            resp_code  <= uepc_pkg::UEPC_RESP_NONE;
        end else begin
            resp_valid <= tok_valid;
            if (tok_valid) begin
                resp_code <= next_resp;
            end
        end
    end

    // Iso IN events count only while that endpoint is enabled.
    assign st_events = {iso_in_extra_token && ep_ctrl[uepc_pkg::EP_ISO_IN][31],
                        iso_in_no_data && ep_ctrl[uepc_pkg::EP_ISO_IN][31],
                        extra_frame_start,
                        frame_start_lost};

    // A read clears the status, but an event in the same cycle survives.
    always_ff @(posedge clock) begin
        if (srst) begin
            second_status <= uepc_pkg::RESET_ST;
        end else if (bus_read && hit_st) begin
            second_status <= st_events;
        end else begin
            second_status <= second_status | st_events;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            second_status_mask <= uepc_pkg::RESET_ST;
        end else if (bus_write && hit_mask) begin
            second_status_mask <= pwdata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            second_status_summary <= 1'b0;
        end else begin
            second_status_summary <= |(second_status & second_status_mask);
        end
    end

    always_comb begin
        for (int i = 0; i < uepc_pkg::NUM_EP; i++) begin
            ep_enable[i] = ep_ctrl[i][uepc_pkg::POS_ENABLE];
        end
    end

    assign control_max_packet  = ep_ctrl[uepc_pkg::EP_CTRL][6:0];
    assign bulk_in_max_packet  = ep_ctrl[uepc_pkg::EP_BULK_IN][6:0];
    assign bulk_out_max_packet = ep_ctrl[uepc_pkg::EP_BULK_OUT][6:0];
    assign intr_in_max_packet  = ep_ctrl[uepc_pkg::EP_INTR_IN][6:0];
    assign intr_out_max_packet = ep_ctrl[uepc_pkg::EP_INTR_OUT][6:0];
    assign iso_in_max_packet   = ep_ctrl[uepc_pkg::EP_ISO_IN][9:0];
    assign iso_out_max_packet  = ep_ctrl[uepc_pkg::EP_ISO_OUT][9:0];
    assign iso_in_tx_mode      = ep_ctrl[uepc_pkg::EP_ISO_IN][uepc_pkg::POS_MODE];
    assign bulk_in_tx_mode     = ep_ctrl[uepc_pkg::EP_BULK_IN][uepc_pkg::POS_MODE];
    assign iso_out_rx_mode     = rx_mode(ep_ctrl[uepc_pkg::EP_ISO_OUT][20:19]);
    assign bulk_out_rx_mode    = rx_mode(ep_ctrl[uepc_pkg::EP_BULK_OUT][20:19]);
    assign iso_out_report_per_packet  = (iso_out_rx_mode == uepc_pkg::UEPC_RX_NORMAL);
    assign bulk_out_report_per_packet = (bulk_out_rx_mode == uepc_pkg::UEPC_RX_NORMAL);
    assign rate_feedback_select = ep_ctrl[uepc_pkg::EP_INTR_IN][uepc_pkg::POS_MODE];

endmodule
`default_nettype wire

/* uepc_pkg.sv */
package uepc_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL_ENDPOINT_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ISO_IN_ENDPOINT_CTRL   = 8'h04;
    localparam logic [7:0] OFS_ISO_OUT_ENDPOINT_CTRL  = 8'h08;
    localparam logic [7:0] OFS_BULK_IN_ENDPOINT_CTRL  = 8'h0c;
    localparam logic [7:0] OFS_BULK_OUT_ENDPOINT_CTRL = 8'h10;
    localparam logic [7:0] OFS_INTR_IN_ENDPOINT_CTRL  = 8'h14;
    localparam logic [7:0] OFS_INTR_OUT_ENDPOINT_CTRL = 8'h18;
    localparam logic [7:0] OFS_SECOND_STATUS          = 8'h1c;
    localparam logic [7:0] OFS_SECOND_STATUS_MASK     = 8'h20;

    // Endpoint numbers.
    localparam int EP_CTRL     = 0;
    localparam int EP_ISO_IN   = 1;
    localparam int EP_ISO_OUT  = 2;
    localparam int EP_BULK_IN  = 3;
    localparam int EP_BULK_OUT = 4;
    localparam int EP_INTR_IN  = 5;
    localparam int EP_INTR_OUT = 6;
    localparam int NUM_EP      = 7;

    // Field positions.
    localparam int POS_ENABLE      = 31;
    localparam int POS_IN_STALL    = 20;
    localparam int POS_IN_NAK      = 19;
    localparam int POS_STALL       = 18;
    localparam int POS_NO_HSK      = 17;
    localparam int POS_NAK         = 16;
    localparam int POS_MODE        = 19;
    localparam int MAXP_SHORT_W    = 7;
    localparam int MAXP_LONG_W     = 10;

    // Writable bits of each endpoint register; the rest read as zero.
    localparam logic [31:0] WMASK_EP0 = 32'h801f007f;
    localparam logic [31:0] WMASK_EP1 = 32'h800803ff;
    localparam logic [31:0] WMASK_EP2 = 32'h801803ff;
    localparam logic [31:0] WMASK_EP3 = 32'h800d007f;
    localparam logic [31:0] WMASK_EP4 = 32'h801f007f;
    localparam logic [31:0] WMASK_EP5 = 32'h800d007f;
    localparam logic [31:0] WMASK_EP6 = 32'h8007007f;
    localparam logic [31:0] RESET_EP  = 32'h00000000;

    // Second status bits.
    localparam int ST_FRAME_START_LOST  = 0;
    localparam int ST_EXTRA_FRAME_START = 1;
    localparam int ST_ISO_IN_NO_DATA    = 2;
    localparam int ST_ISO_IN_EXTRA_TOK  = 3;
    localparam int ST_W                 = 4;
    localparam logic [3:0] RESET_ST     = 4'h0;

    typedef enum logic [1:0] {
        UEPC_TOK_SETUP,
        UEPC_TOK_IN,
        UEPC_TOK_OUT
    } uepc_tok_t;

    typedef enum logic [2:0] {
        UEPC_RESP_NONE,
        UEPC_RESP_ACK,
        UEPC_RESP_NAK,
        UEPC_RESP_STALL,
        UEPC_RESP_DATA
    } uepc_resp_t;

    typedef enum logic [1:0] {
        UEPC_RX_NORMAL,
        UEPC_RX_ASSEMBLE,
        UEPC_RX_SEPARATE
    } uepc_rx_mode_t;

endpackage

/* uepc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module uepc_props #(
    parameter int ADDR_W = 8
) (
    // Clock, reset and bus.
    input wire logic                 clock,
    input wire logic                 srst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic                 pslverr,
    // Token path.
    input wire logic                 tok_valid,
    input wire logic [3:0]           tok_ep,
    input wire uepc_pkg::uepc_tok_t  tok_kind,
    input wire logic                 resp_valid,
    input wire uepc_pkg::uepc_resp_t resp_code,
    // Events and configuration.
    input wire logic                 iso_in_extra_token,
    input wire logic                 iso_in_no_data,
    input wire logic                 extra_frame_start,
    input wire logic                 frame_start_lost,
    input wire logic                 second_status_summary,
    input wire logic [6:0]           ep_enable,
    input wire logic [1:0]           iso_out_rx_mode,
    input wire logic                 iso_out_report_per_packet
);
    logic ep0_tok, sticky, ev_any, ep0_use;

    assign ev_any = iso_in_extra_token | iso_in_no_data | extra_frame_start | frame_start_lost;
    assign ep0_use = tok_valid && tok_ep == 4'h0 && ep_enable[0];

    always_ff @(posedge clock) begin
        ep0_tok <= !srst && tok_valid && tok_ep == 4'h0;
    end

    // A control stall is remembered until the next SETUP while endpoint 0 is enabled, so later tokens can be judged.
    always_ff @(posedge clock) begin
        if (srst || (ep0_use && tok_kind == uepc_pkg::UEPC_TOK_SETUP)) begin
            sticky <= 1'b0;
        end else if (resp_valid && ep0_tok && resp_code == uepc_pkg::UEPC_RESP_STALL) begin
            sticky <= 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_resp_timing;
        resp_valid == $past(tok_valid);
    endproperty
    property p_ep0_off;
        tok_valid && tok_ep == 4'h0 && !ep_enable[0] |=> resp_code == uepc_pkg::UEPC_RESP_NONE;
    endproperty
    property p_setup_ack;
        ep0_use && tok_kind == uepc_pkg::UEPC_TOK_SETUP |=> resp_code == uepc_pkg::UEPC_RESP_ACK;
    endproperty
    property p_sticky;
        ep0_use && sticky && tok_kind != uepc_pkg::UEPC_TOK_SETUP
            |=> resp_code == uepc_pkg::UEPC_RESP_STALL;
    endproperty
    property p_bad_ep;
        tok_valid && tok_ep > 4'h6 |=> resp_code == uepc_pkg::UEPC_RESP_NONE;
    endproperty
    property p_code_hold;
        !tok_valid |=> $stable(resp_code);
    endproperty
    property p_unmapped;
        psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'b00) |-> pslverr;
    endproperty
    property p_read_clear;
        psel && penable && !pwrite && paddr == uepc_pkg::OFS_SECOND_STATUS && !ev_any
            |-> ##2 !second_status_summary;
    endproperty
    property p_report;
        iso_out_report_per_packet == (iso_out_rx_mode == uepc_pkg::UEPC_RX_NORMAL);
    endproperty

    a_resp_timing: assert property (p_resp_timing) else $error("response timing wrong");
    a_ep0_off: assert property (p_ep0_off) else $error("disabled control answered");
    a_setup_ack: assert property (p_setup_ack) else $error("setup not acknowledged");
    a_sticky: assert property (p_sticky) else $error("stall not held");
    a_bad_ep: assert property (p_bad_ep) else $error("unknown endpoint answered");
    a_code_hold: assert property (p_code_hold) else $error("response changed idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped without error");
    a_read_clear: assert property (p_read_clear) else $error("summary after clear");
    a_report: assert property (p_report) else $error("report mode wrong");

    c_sticky: cover property (ep0_use && sticky);
    c_nak: cover property (resp_valid && resp_code == uepc_pkg::UEPC_RESP_NAK);
    c_summary: cover property (second_status_summary);
endmodule
bind uepc_top uepc_props #(.ADDR_W(ADDR_W)) i_uepc_props (
    .clock, .srst, .psel, .penable, .pwrite, .paddr, .pslverr, .tok_valid, .tok_ep, .tok_kind,
    .resp_valid, .resp_code, .iso_in_extra_token, .iso_in_no_data, .extra_frame_start,
    .frame_start_lost, .second_status_summary, .ep_enable, .iso_out_rx_mode,
    .iso_out_report_per_packet
);
`default_nettype wire

/* uepc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uepc_host_model (
    // Clock.
    input  wire logic                 clock,
    // Token path.
    output logic                      tok_valid,
    output logic [3:0]                tok_ep,
    output uepc_pkg::uepc_tok_t       tok_kind,
    input  wire logic                 resp_valid,
    input  wire uepc_pkg::uepc_resp_t resp_code,
    // Frame events, bit order as in the status register.
    output logic [3:0]                events
);
    initial begin
        tok_valid = 1'b0;
        tok_ep = 4'h0;
        tok_kind = uepc_pkg::UEPC_TOK_SETUP;
        events = 4'h0;
    end

    task automatic xfer(input logic [3:0] ep, input uepc_pkg::uepc_tok_t kind,
                        output logic ok, output uepc_pkg::uepc_resp_t code);
        @(posedge clock);
        tok_valid <= 1'b1;
        tok_ep <= ep;
        tok_kind <= kind;
        @(posedge clock);
        tok_valid <= 1'b0;
        #1;
        ok = resp_valid;
        code = resp_code;
    endtask

    task automatic pulse(input logic [3:0] which);
        @(posedge clock);
        events <= which;
        @(posedge clock);
        events <= 4'h0;
    endtask
endmodule
`default_nettype wire

/* tb_usb_endpoint_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_control_regs;
    localparam uepc_pkg::uepc_tok_t  SU = uepc_pkg::UEPC_TOK_SETUP;
    localparam uepc_pkg::uepc_tok_t  TI = uepc_pkg::UEPC_TOK_IN;
    localparam uepc_pkg::uepc_tok_t  TO = uepc_pkg::UEPC_TOK_OUT;
    localparam uepc_pkg::uepc_resp_t NO = uepc_pkg::UEPC_RESP_NONE;
    localparam uepc_pkg::uepc_resp_t AK = uepc_pkg::UEPC_RESP_ACK;
    localparam uepc_pkg::uepc_resp_t NK = uepc_pkg::UEPC_RESP_NAK;
    localparam uepc_pkg::uepc_resp_t ST = uepc_pkg::UEPC_RESP_STALL;
    localparam uepc_pkg::uepc_resp_t DT = uepc_pkg::UEPC_RESP_DATA;
    localparam logic [7:0]           STA = uepc_pkg::OFS_SECOND_STATUS;
    localparam logic [7:0]           MSK = uepc_pkg::OFS_SECOND_STATUS_MASK;

    logic                    clock, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata;
    logic                    tok_valid, resp_valid, summary;
    logic [3:0]              tok_ep, ev;
    uepc_pkg::uepc_tok_t     tok_kind;
    uepc_pkg::uepc_resp_t    resp_code;
    logic [6:0]              ep_enable;
    logic [6:0]              mp0, mp3, mp4, mp5, mp6;
    logic [9:0]              mp1, mp2;
    logic                    tx1, tx3, rpp2, rpp4, fb;
    uepc_pkg::uepc_rx_mode_t rx2, rx4;
    int                      n_mismatch, compares;

    uepc_top i_uepc_top (
        .clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tok_valid, .tok_ep, .tok_kind, .resp_valid, .resp_code, .ep_enable,
        .iso_in_extra_token(ev[3]), .iso_in_no_data(ev[2]), .extra_frame_start(ev[1]),
        .frame_start_lost(ev[0]), .second_status_summary(summary),
        .control_max_packet(mp0), .iso_in_max_packet(mp1), .iso_out_max_packet(mp2),
        .bulk_in_max_packet(mp3), .bulk_out_max_packet(mp4), .intr_in_max_packet(mp5),
        .intr_out_max_packet(mp6), .iso_in_tx_mode(tx1), .bulk_in_tx_mode(tx3),
        .iso_out_rx_mode(rx2), .bulk_out_rx_mode(rx4), .iso_out_report_per_packet(rpp2),
        .bulk_out_report_per_packet(rpp4), .rate_feedback_select(fb)
    );

    uepc_host_model i_uepc_host_model (
        .clock, .tok_valid, .tok_ep, .tok_kind, .resp_valid, .resp_code, .events(ev)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [3:0] ep, input uepc_pkg::uepc_tok_t k,
                            input uepc_pkg::uepc_resp_t exp);
        logic                 ok;
        uepc_pkg::uepc_resp_t c;
        i_uepc_host_model.xfer(ep, k, ok, c);
        compares++;
        if (ok !== 1'b1 || c !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: endpoint %0d answer %0d expected %0d", $time, ep, c, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        cmp(r, exp);
    endtask

    task automatic chk(input logic [3:0] ep, input logic [31:0] v, input uepc_pkg::uepc_tok_t k,
                       input uepc_pkg::uepc_resp_t e);
        wr({2'b00, ep, 2'b00}, v);
        cmp_resp(ep, k, e);
    endtask

    function automatic uepc_pkg::uepc_rx_mode_t rxm(input int m);
        return uepc_pkg::uepc_rx_mode_t'(m < 2 ? 0 : m - 1);
    endfunction

    task automatic t_regs;
        logic [31:0] m [7] = '{uepc_pkg::WMASK_EP0, uepc_pkg::WMASK_EP1, uepc_pkg::WMASK_EP2,
            uepc_pkg::WMASK_EP3, uepc_pkg::WMASK_EP4, uepc_pkg::WMASK_EP5, uepc_pkg::WMASK_EP6};
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), 32'h0);
            wr(8'(4 * i), 32'hffffffff);
            rd(8'(4 * i), m[i]);
            wr(8'(4 * i), 32'h0);
        end
        rd(MSK, 32'h0);
        apb(1'b1, 8'h24, 32'hffffffff, r, e);
        cmp(32'(e), 32'h1);
        apb(1'b0, 8'h24, 32'h0, r, e);
        cmp({r[31:1], e}, 32'h1);
    endtask

    task automatic t_fields;
        wr(8'h04, 32'h800803ff);
        wr(8'h0c, 32'h0008007f);
        wr(8'h14, 32'h00080055);
        #1;
        cmp(32'({ep_enable, mp1, tx1, tx3, fb}), 32'h00005fff);
        cmp(32'({mp3, mp5}), 32'h00003fd5);
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, (32'(i) << 19) | 32'h000002aa);
            wr(8'h10, 32'(3 - i) << 19);
            #1;
            cmp(32'({rx2, rx4, rpp2, rpp4}), 32'({rxm(i), rxm(3 - i), i < 2, i > 1}));
            cmp(32'(mp2), 32'h2aa);
        end
    endtask

    task automatic t_ep0;
        chk(0, 32'h00000000, TI, NO);
        chk(0, 32'h80000000, TI, DT);
        chk(0, 32'h80080000, TI, NK);
        chk(0, 32'h80180000, TI, ST);
        chk(0, 32'h80000000, TO, ST);
        chk(0, 32'h80000000, SU, AK);
        chk(0, 32'h80000000, TI, DT);
        chk(0, 32'h801d0000, SU, AK);
        rd(8'h00, 32'h80090000);
        chk(0, 32'h80040000, TO, ST);
        chk(0, 32'h80000000, SU, AK);
        chk(0, 32'h80010000, TO, NK);
        chk(0, 32'h80020000, TO, NO);
        chk(0, 32'h80030000, TO, NK);
        chk(0, 32'h80000000, TO, AK);
    endtask

    task automatic t_others;
        chk(3, 32'h00010000, TI, NO);
        chk(3, 32'h80000000, TI, DT);
        chk(3, 32'h80010000, TI, NK);
        chk(3, 32'h80050000, TI, ST);
        for (int e = 4; e < 7; e += 2) begin
            chk(4'(e), 32'h80000000, TO, AK);
            chk(4'(e), 32'h80010000, TO, NK);
            chk(4'(e), 32'h80020000, TO, NO);
            chk(4'(e), 32'h80050000, TO, ST);
        end
        chk(5, 32'h80010000, TI, NK);
        chk(5, 32'h80050000, TI, ST);
        chk(1, 32'h80000000, TI, DT);
        chk(2, 32'h80000000, TO, NO);
        cmp_resp(7, TI, NO);
    endtask

    task automatic t_status;
        wr(8'h04, 32'h80000000);
        wr(MSK, 32'h0000000f);
        for (int i = 0; i < 4; i++) begin
            i_uepc_host_model.pulse(4'(1 << i));
            repeat (2) @(posedge clock);
            #1;
            cmp(32'(summary), 32'h1);
            rd(STA, 32'(1 << i));
            rd(STA, 32'h0);
        end
        wr(MSK, 32'h0000000e);
        i_uepc_host_model.pulse(4'h1);
        repeat (2) @(posedge clock);
        #1;
        cmp(32'(summary), 32'h0);
        rd(STA, 32'h1);
    endtask

    task automatic tally_and_finish;
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        n_mismatch = 0;
        compares = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        t_regs;
        t_fields;
        t_ep0;
        t_others;
        t_status;
        tally_and_finish;
    end

    // Whole run needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
